// ### src/power_saving_mode_control.sv
// Power-mode controller: run, slow, wait, active-halt, halt and restart.
// Assumes the core pulses its wait/halt instructions and wake sources are
// synchronous to CLK; registers are reached over an APB slave.
`timescale 1ns/1ns
module power_saving_mode_control
    import pwr_mode_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic WAIT_INSTR,
    input wire logic HALT_INSTR,
    input wire logic WATCHDOG_ACTIVE,
    input wire logic LITE_TIMER_IRQ,
    input wire logic AUTORELOAD_TIMER_IRQ,
    input wire logic HALT_WAKE_IRQ,
    input wire logic ANY_IRQ,
    input wire logic WAKE_RESET,
    input wire logic IRQ_SERVICE,
    input wire logic FLAGS_POP,
    input wire logic SAVED_MASK,
    output logic CPU_CLK_EN,
    output logic PERIPH_CLK_EN,
    output logic OSC_ON,
    output logic TIMER_CLK_EN,
    output logic IRQ_MASK,
    output logic PUSH_FLAGS,
    output logic VECTOR_FETCH,
    output logic RESET_VECTOR,
    output logic WATCHDOG_RESET,
    output logic [2:0] MODE
);

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire access = PSEL && PENABLE;
    wire wr = access && PWRITE;
    wire hit_mccs = (PADDR == OFS_MAIN_CLOCK_CTRL_STATUS);
    wire hit_tcfg = (PADDR == OFS_TIMER_CFG);
    wire hit_stat = (PADDR == OFS_MODE_STATUS);
    wire mapped = hit_mccs || hit_tcfg || hit_stat;

    logic [1:0] main_clock_ctrl_status; // Bit 0 slow select, bit 1 clock out
    logic [4:0] timer_cfg; // Copies of timer enables and watchdog option
    mode_e mode; // Present operating mode
    logic from_halt; // Restart came out of a full halt
    logic irq_pending_exit; // Restart ends by interrupt, not reset vector
    logic [8:0] restart_count; // Cycles spent restarting
    logic tick; // Slow-mode enable pulse

    // Register writes steer the block; slow select at bit 0
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            main_clock_ctrl_status <= MCCS_RESET;
            timer_cfg <= TIMER_CFG_RESET;
        end
        else if (wr && hit_mccs)
            main_clock_ctrl_status <= PWDATA[1:0];
        else if (wr && hit_tcfg)
            timer_cfg <= PWDATA[4:0];
    end

    // Read mux; status register shows mode and restart count
    wire [31:0] next_prdata =
        hit_mccs ? {30'h0, main_clock_ctrl_status} :
        hit_tcfg ? {27'h0, timer_cfg} :
        hit_stat ? {20'h0, restart_count, mode} : 32'h0;

    // Zero-wait slave; unmapped addresses answer with an error
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            PRDATA <= 32'h0;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PRDATA <= (PSEL && !PENABLE && !PWRITE) ? next_prdata : PRDATA;
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !mapped;
        end
    end

    // ------------------------------------------------------------
    // Mode decisions
    // ------------------------------------------------------------
    wire slow = main_clock_ctrl_status[SLOW_SELECT_BIT];
    // Clock select pattern 0 then 1 means hi=0, lo=1
    wire active_halt_en = timer_cfg[TIMEBASE_IRQ_ENABLE] ||
        (timer_cfg[OVERFLOW_IRQ_ENABLE] && !timer_cfg[AUTORELOAD_CLKSEL_HI] &&
         timer_cfg[AUTORELOAD_CLKSEL_LO]);
    wire wdg_opt = timer_cfg[WATCHDOG_ON_HALT_OPTION];
    // Option clear with watchdog running resets on full halt; active-halt never
    wire halt_wdg_reset = HALT_INSTR && WATCHDOG_ACTIVE && !wdg_opt &&
        !active_halt_en;
    wire ah_wake_irq = LITE_TIMER_IRQ || AUTORELOAD_TIMER_IRQ;
    wire restart_done = (restart_count == RESTART_LAST);
    wire run_instr = (mode == MODE_RUN) && !halt_wdg_reset;

    // Next mode
    mode_e next_mode;
    always_comb
    begin
        next_mode = mode;
        unique case (mode)
            MODE_RUN:
                if (run_instr && HALT_INSTR)
                    next_mode = active_halt_en ? MODE_ACTIVE_HALT : MODE_HALT;
                else if (WAIT_INSTR)
                    next_mode = MODE_WAIT;
            MODE_WAIT:
                if (ANY_IRQ || WAKE_RESET)
                    next_mode = MODE_RUN;
            MODE_ACTIVE_HALT:
                if (WAKE_RESET)
                    next_mode = MODE_RESTART;
                else if (ah_wake_irq)
                    next_mode = MODE_RUN;
            MODE_HALT:
                if (WAKE_RESET || HALT_WAKE_IRQ)
                    next_mode = MODE_RESTART;
            MODE_RESTART:
                if (restart_done)
                    next_mode = MODE_RUN;
            default:
                next_mode = MODE_RUN;
        endcase
    end

    // Mode register and restart bookkeeping
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            mode <= MODE_RUN;
            from_halt <= 1'b0;
            irq_pending_exit <= 1'b0;
        end
        else
        begin
            mode <= next_mode;
            if (mode == MODE_HALT && next_mode == MODE_RESTART)
            begin
                from_halt <= 1'b1;
                irq_pending_exit <= !WAKE_RESET; // Reset beats interrupt
            end
            else if (mode == MODE_ACTIVE_HALT && next_mode == MODE_RESTART)
            begin
                from_halt <= 1'b0;
                irq_pending_exit <= 1'b0;
            end
        end
    end

    // Restart counter: oscillator settles for 256 cycles
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            restart_count <= 9'h000;
        else if (mode == MODE_RESTART)
            restart_count <= restart_count + 9'h001;
        else
            restart_count <= 9'h000;
    end

    // ------------------------------------------------------------
    // Clock gating
    // ------------------------------------------------------------
    // Oscillator stops only in full halt; it runs again for the restart count
    wire osc_run = (mode != MODE_HALT);
    slow_divider u_div
    (
        .CLK(CLK),
        .RST_N(RST_N),
        .slow(slow),
        .run(osc_run),
        .tick(tick)
    );

    wire next_cpu_en = tick && (next_mode == MODE_RUN);
    // Peripherals run in run and wait, slow-wait keeps the divided tick
    wire next_periph_en = tick &&
        (next_mode == MODE_RUN || next_mode == MODE_WAIT);
    wire next_timer_en = tick && (next_mode != MODE_HALT) &&
        (next_mode != MODE_RESTART || !from_halt);
    wire next_osc = (next_mode != MODE_HALT);
    // Enables travel together toward the core and clock tree
    wire clk_ctl_s next_clk = {next_cpu_en, next_periph_en, next_osc, next_timer_en};

    // Clock outputs registered; they follow the next mode
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            CPU_CLK_EN <= 1'b0;
            PERIPH_CLK_EN <= 1'b0;
            TIMER_CLK_EN <= 1'b0;
            OSC_ON <= 1'b1;
        end
        else
        begin
            CPU_CLK_EN <= next_clk.cpu_clk_en;
            PERIPH_CLK_EN <= next_clk.periph_clk_en;
            TIMER_CLK_EN <= next_clk.timer_clk_en;
            OSC_ON <= next_clk.osc_on;
        end
    end

    // ------------------------------------------------------------
    // Interrupt mask and service handshake
    // ------------------------------------------------------------
    wire enter_low = (mode == MODE_RUN) &&
        (next_mode == MODE_WAIT || next_mode == MODE_ACTIVE_HALT ||
         next_mode == MODE_HALT);

    // Service sets the mask; a pop restores it; entry clears it
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            IRQ_MASK <= 1'b1;
        else if (IRQ_SERVICE)
            IRQ_MASK <= 1'b1;
        else if (enter_low)
            IRQ_MASK <= 1'b0;
        else if (FLAGS_POP)
            IRQ_MASK <= SAVED_MASK;
    end

    // Exit strobes: vector request and push of flags, one cycle each
    wire irq_exit = (mode == MODE_WAIT && ANY_IRQ && !WAKE_RESET) ||
        (mode == MODE_ACTIVE_HALT && ah_wake_irq && !WAKE_RESET) ||
        (mode == MODE_RESTART && restart_done && irq_pending_exit);
    wire rst_exit = (mode == MODE_WAIT && WAKE_RESET) ||
        (mode == MODE_RESTART && restart_done && !irq_pending_exit);

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            VECTOR_FETCH <= 1'b0;
            RESET_VECTOR <= 1'b0;
            PUSH_FLAGS <= 1'b0;
            WATCHDOG_RESET <= 1'b0;
            MODE <= 3'h0;
        end
        else
        begin
            VECTOR_FETCH <= irq_exit || rst_exit;
            RESET_VECTOR <= rst_exit;
            PUSH_FLAGS <= irq_exit;
            WATCHDOG_RESET <= halt_wdg_reset;
            MODE <= next_mode;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_restart_length: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(mode == MODE_RESTART) |-> (mode == MODE_RESTART) [*8])
        else $error("restart ended too early");
    chk_restart_exit: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(mode == MODE_RESTART) |-> ##[255:257] (mode == MODE_RUN))
        else $error("restart not 256 cycles");
    chk_ah_irq_fast: assert property (@(posedge CLK) disable iff (!RST_N)
        (mode == MODE_ACTIVE_HALT && ah_wake_irq && !WAKE_RESET) |=> mode == MODE_RUN)
        else $error("active-halt interrupt exit not immediate");
    chk_ah_only_timer: assert property (@(posedge CLK) disable iff (!RST_N)
        (mode == MODE_ACTIVE_HALT && !ah_wake_irq && !WAKE_RESET) |=>
        mode == MODE_ACTIVE_HALT)
        else $error("active-halt left without timer wake");
    chk_halt_choice: assert property (@(posedge CLK) disable iff (!RST_N)
        (mode == MODE_RUN && HALT_INSTR && !halt_wdg_reset) |=>
        mode == ($past(active_halt_en) ? MODE_ACTIVE_HALT : MODE_HALT))
        else $error("wrong halt variant");
    chk_mask_entry: assert property (@(posedge CLK) disable iff (!RST_N)
        (enter_low && !IRQ_SERVICE) |=> !IRQ_MASK)
        else $error("mask not cleared on entry");
    chk_osc_halt: assert property (@(posedge CLK) disable iff (!RST_N)
        (mode == MODE_HALT) |-> !OSC_ON && !CPU_CLK_EN && !PERIPH_CLK_EN)
        else $error("clocks run in full halt");
    chk_slow_tick: assert property (@(posedge CLK) disable iff (!RST_N)
        (CPU_CLK_EN && slow && $stable(slow) && mode == MODE_RUN) |=>
        !CPU_CLK_EN [*8])
        else $error("slow clock too fast");
    chk_ah_no_wdg: assert property (@(posedge CLK) disable iff (!RST_N)
        (HALT_INSTR && active_halt_en) |=> !WATCHDOG_RESET)
        else $error("watchdog reset in active-halt");
    chk_wait_wake: assert property (@(posedge CLK) disable iff (!RST_N)
        (mode == MODE_WAIT && ANY_IRQ && !WAKE_RESET) |=>
        (mode == MODE_RUN && VECTOR_FETCH && PUSH_FLAGS))
        else $error("wait not left on interrupt");
    chk_wait_cpu_off: assert property (@(posedge CLK) disable iff (!RST_N)
        (mode == MODE_WAIT) |-> !CPU_CLK_EN)
        else $error("cpu clocked during wait");
    chk_wdg_reset: assert property (@(posedge CLK) disable iff (!RST_N)
        (mode == MODE_RUN && HALT_INSTR && !WAIT_INSTR && WATCHDOG_ACTIVE && !wdg_opt &&
         !active_halt_en) |=> (WATCHDOG_RESET && mode == MODE_RUN))
        else $error("no watchdog reset on halt");
    chk_halt_timer_off: assert property (@(posedge CLK) disable iff (!RST_N)
        (mode == MODE_HALT) |-> !TIMER_CLK_EN)
        else $error("timer clocked in full halt");
    chk_mask_pop: assert property (@(posedge CLK) disable iff (!RST_N)
        (FLAGS_POP && !IRQ_SERVICE && !enter_low) |=> IRQ_MASK == $past(SAVED_MASK))
        else $error("mask not restored by pop");
    chk_service_mask: assert property (@(posedge CLK) disable iff (!RST_N)
        IRQ_SERVICE |=> IRQ_MASK)
        else $error("mask not set by service");
    chk_ah_clocks: assert property (@(posedge CLK) disable iff (!RST_N)
        (mode == MODE_ACTIVE_HALT) |-> (OSC_ON && !PERIPH_CLK_EN && !CPU_CLK_EN))
        else $error("wrong clocks in active-halt");

endmodule

// ### src/pwr_mode_pkg.sv
// Package for the power-mode controller: register map, fields, modes, timing.
// Assumes a 20 MHz system clock and an APB slave with 32-bit data.
package pwr_mode_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_MAIN_CLOCK_CTRL_STATUS = 8'h00;
    localparam logic [7:0] OFS_TIMER_CFG = 8'h04;
    localparam logic [7:0] OFS_MODE_STATUS = 8'h08;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int SLOW_SELECT_BIT = 0;
    localparam logic [1:0] MCCS_RESET = 2'h0;
    localparam int TIMEBASE_IRQ_ENABLE = 0;
    localparam int OVERFLOW_IRQ_ENABLE = 1;
    localparam int AUTORELOAD_CLKSEL_LO = 2;
    localparam int AUTORELOAD_CLKSEL_HI = 3;
    localparam int WATCHDOG_ON_HALT_OPTION = 4;
    localparam logic [4:0] TIMER_CFG_RESET = 5'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SLOW_DIVIDE = 32;
    localparam int RESTART_CYCLES = 256;
    localparam logic [4:0] SLOW_DIV_LAST = 5'(SLOW_DIVIDE - 1);
    localparam logic [8:0] RESTART_LAST = 9'(RESTART_CYCLES - 1);

    // ------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        MODE_RUN = 3'b000,
        MODE_WAIT = 3'b001,
        MODE_ACTIVE_HALT = 3'b010,
        MODE_HALT = 3'b011,
        MODE_RESTART = 3'b100
    } mode_e;

    // Controls that leave toward the core and clock tree
    typedef struct packed
    {
        logic cpu_clk_en;
        logic periph_clk_en;
        logic osc_on;
        logic timer_clk_en;
    } clk_ctl_s;

endpackage

// ### src/slow_divider.sv
// Divides the oscillator-rate clock into a one-cycle enable pulse.
// Assumes one clock; when slow mode is off every cycle with run high is enabled.
`timescale 1ns/1ns
module slow_divider
    import pwr_mode_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic slow,
    input wire logic run,
    output logic tick
);

    // ------------------------------------------------------------
    // Divider counter
    // ------------------------------------------------------------
    logic [4:0] count; // Position inside one slow period
    wire wrap = (count == SLOW_DIV_LAST);

    // Count only while the oscillator is running
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            count <= 5'h00;
        else if (!run || !slow)
            count <= 5'h00;
        else
            count <= count + 5'h01;
    end

    // While running, tick once per 32 cycles in slow mode, every cycle otherwise
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            tick <= 1'b0;
        else
            tick <= run && (!slow || wrap);
    end

endmodule

// ### bench/core_model.sv
// Core-side partner: wait and halt instruction pulses on request, and
// entry into a service routine after each vector that is not a reset.
// Assumes the bench holds each request high for exactly one cycle.
`timescale 1ns/1ns
module core_model
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic wait_req,
    input wire logic halt_req,
    input wire logic vector_fetch,
    input wire logic reset_vector,
    output logic wait_instr,
    output logic halt_instr,
    output logic irq_service
);
    // ------------------------------------------------------------
    // Instruction issue and service entry
    // ------------------------------------------------------------
    // Halt is issued one cycle after each halt request, with no check
    // on the clock source or on what was fetched
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            wait_instr <= 1'b0;
            halt_instr <= 1'b0;
            irq_service <= 1'b0;
        end
        else
        begin
            wait_instr <= wait_req;
            halt_instr <= halt_req;
            irq_service <= vector_fetch & ~reset_vector;
        end
    end
endmodule

// ### bench/tb.sv
// Self-checking bench for the power-mode controller.
// Assumes the core partner model; APB master and wake pulses live here.
`timescale 1ns/1ns
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
    $display("ERROR %0t: got %h exp %h", $time, (a), (e)); end end
module tb
    import pwr_mode_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR, WAIT_INSTR, HALT_INSTR, IRQ_SERVICE;
    logic WATCHDOG_ACTIVE = 1'b0;
    logic wait_req = 1'b0;
    logic halt_req = 1'b0;
    logic FLAGS_POP = 1'b0;
    logic SAVED_MASK = 1'b0;
    logic [4:0] wk = 5'h00; // Reset, any, halt-wake, reload, lite
    wire logic WAKE_RESET, ANY_IRQ, HALT_WAKE_IRQ, AUTORELOAD_TIMER_IRQ, LITE_TIMER_IRQ;
    logic CPU_CLK_EN, PERIPH_CLK_EN, OSC_ON, TIMER_CLK_EN, IRQ_MASK;
    logic PUSH_FLAGS, VECTOR_FETCH, RESET_VECTOR, WATCHDOG_RESET;
    logic [2:0] MODE;
    logic [31:0] q; // Last read data
    logic e; // Last error response
    int failures = 0;
    int num_checks = 0;
    int c, p;
    // Rows: expected active-halt in bit 4, timer bits below
    logic [4:0] rows [7] = '{5'h00, 5'h11, 5'h16, 5'h0e, 5'h02, 5'h0a, 5'h1d};
    logic [4:0] wd [3] = '{5'h00, 5'h10, 5'h01}; // Option bit 4, timebase bit 0
    logic [2:0] wm [3] = '{3'h0, 3'h3, 3'h2}; // Mode after halt
    assign {WAKE_RESET, ANY_IRQ, HALT_WAKE_IRQ, AUTORELOAD_TIMER_IRQ, LITE_TIMER_IRQ} = wk;
    always #25 CLK = ~CLK;

    core_model core (.CLK(CLK), .RST_N(RST_N), .wait_req(wait_req), .halt_req(halt_req),
        .vector_fetch(VECTOR_FETCH), .reset_vector(RESET_VECTOR),
        .wait_instr(WAIT_INSTR), .halt_instr(HALT_INSTR), .irq_service(IRQ_SERVICE));

    // Flag pop is driven by the bench to check the mask restore
    power_saving_mode_control DUT (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .WAIT_INSTR(WAIT_INSTR),
        .HALT_INSTR(HALT_INSTR), .WATCHDOG_ACTIVE(WATCHDOG_ACTIVE),
        .LITE_TIMER_IRQ(LITE_TIMER_IRQ), .AUTORELOAD_TIMER_IRQ(AUTORELOAD_TIMER_IRQ),
        .HALT_WAKE_IRQ(HALT_WAKE_IRQ), .ANY_IRQ(ANY_IRQ), .WAKE_RESET(WAKE_RESET),
        .IRQ_SERVICE(IRQ_SERVICE), .FLAGS_POP(FLAGS_POP), .SAVED_MASK(SAVED_MASK),
        .CPU_CLK_EN(CPU_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN), .OSC_ON(OSC_ON),
        .TIMER_CLK_EN(TIMER_CLK_EN), .IRQ_MASK(IRQ_MASK), .PUSH_FLAGS(PUSH_FLAGS),
        .VECTOR_FETCH(VECTOR_FETCH), .RESET_VECTOR(RESET_VECTOR),
        .WATCHDOG_RESET(WATCHDOG_RESET), .MODE(MODE));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // One APB transfer; waits for ready under a bound
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do
        begin
            @(posedge CLK);
            n++;
        end
        while (PREADY !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            $display("ERROR %0t: no ready from slave", $time);
            failures++;
        end
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    // Wait (w=1) or halt (w=0) through the core; ends where mode has settled
    task automatic instr(input logic w);
        @(posedge CLK);
        wait_req <= w;
        halt_req <= !w;
        @(posedge CLK);
        wait_req <= 1'b0;
        halt_req <= 1'b0;
        @(posedge CLK);
        @(negedge CLK);
    endtask

    // One-cycle wake request; ends after the edge that sees it
    task automatic pulse(input logic [4:0] v);
        @(posedge CLK);
        wk <= v;
        @(posedge CLK);
        wk <= 5'h00;
        @(negedge CLK);
    endtask

    // One flag pop carrying the saved mask
    task automatic pop(input logic m);
        @(posedge CLK);
        FLAGS_POP <= 1'b1;
        SAVED_MASK <= m;
        @(posedge CLK);
        FLAGS_POP <= 1'b0;
        @(negedge CLK);
    endtask

    // Length of the restart stretch, bounded
    task automatic wait_run();
        c = 0;
        while (MODE === 3'h4 && c < 400)
        begin
            c++;
            @(negedge CLK);
        end
    endtask

    // Clock enables seen over 64 cycles
    task automatic cnt();
        c = 0;
        p = 0;
        repeat (64)
        begin
            @(negedge CLK);
            c += int'(CPU_CLK_EN === 1'b1);
            p += int'(PERIPH_CLK_EN === 1'b1);
        end
    endtask

    task automatic summarize();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Watchdog: the whole run needs well under 8000 cycles
    // ------------------------------------------------------------
    initial
    begin
        repeat (20000) @(posedge CLK);
        $display("ERROR %0t: run did not finish", $time);
        failures++;
        summarize();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        @(negedge CLK);
        `CHK(CPU_CLK_EN, 1'b0)
        @(negedge CLK);
        `CHK(CPU_CLK_EN, 1'b0)
        @(negedge CLK);
        `CHK(CPU_CLK_EN, 1'b1)
        `CHK(MODE, 3'h0)
        `CHK(OSC_ON, 1'b1)
        apb(1'b0, OFS_MAIN_CLOCK_CTRL_STATUS, 32'h0);
        `CHK(q[1:0], MCCS_RESET)
        apb(1'b0, OFS_TIMER_CFG, 32'h0);
        `CHK(q[4:0], TIMER_CFG_RESET)
        apb(1'b0, 8'h0c, 32'h0);
        `CHK(e, 1'b1)
        apb(1'b0, OFS_MODE_STATUS, 32'h0);
        `CHK(q, 32'h0)
        $display("reset test done");
        // Halt decision table; active-halt rows wake by timer, halt rows by irq
        foreach (rows[i])
        begin
            apb(1'b1, OFS_TIMER_CFG, {28'h0, rows[i][3:0]});
            instr(1'b0);
            `CHK(MODE, rows[i][4] ? 3'h2 : 3'h3)
            `CHK(IRQ_MASK, 1'b0)
            `CHK(OSC_ON, rows[i][4])
            `CHK(TIMER_CLK_EN, rows[i][4])
            `CHK(PERIPH_CLK_EN, 1'b0)
            if (rows[i][4])
            begin
                pulse(i[0] ? 5'h02 : 5'h01);
                `CHK(MODE, 3'h0)
            end
            else
            begin
                pulse(5'h04);
                wait_run();
                `CHK(c, RESTART_CYCLES)
            end
            `CHK(VECTOR_FETCH, 1'b1)
            `CHK(PUSH_FLAGS, 1'b1)
            `CHK(RESET_VECTOR, 1'b0)
            repeat (3) @(negedge CLK);
            `CHK(IRQ_MASK, 1'b1)
            $display("halt row %0d done", i);
        end
        // A pop restores whichever mask was pushed
        pop(1'b0);
        `CHK(IRQ_MASK, 1'b0)
        pop(1'b1);
        `CHK(IRQ_MASK, 1'b1)
        $display("flag pop test done");
        // Wait in normal then slow clocking
        instr(1'b1);
        `CHK(MODE, 3'h1)
        `CHK(IRQ_MASK, 1'b0)
        cnt();
        `CHK(c, 0)
        `CHK(p, 64)
        pulse(5'h08);
        `CHK(MODE, 3'h0)
        `CHK(VECTOR_FETCH, 1'b1)
        apb(1'b1, OFS_MAIN_CLOCK_CTRL_STATUS, 32'h1);
        apb(1'b0, OFS_MAIN_CLOCK_CTRL_STATUS, 32'h0);
        `CHK(q[0], 1'b1)
        cnt();
        `CHK(c, 64 / SLOW_DIVIDE)
        `CHK(p, 64 / SLOW_DIVIDE)
        instr(1'b1);
        cnt();
        `CHK(c, 0)
        `CHK(p, 64 / SLOW_DIVIDE)
        pulse(5'h08);
        apb(1'b1, OFS_MAIN_CLOCK_CTRL_STATUS, 32'h0);
        $display("wait test done");
        // Active-halt ignores other sources; reset exit takes the restart
        apb(1'b1, OFS_TIMER_CFG, 32'h1);
        instr(1'b0);
        pulse(5'h0c);
        `CHK(MODE, 3'h2)
        pulse(5'h10);
        wait_run();
        `CHK(c, RESTART_CYCLES)
        `CHK(RESET_VECTOR, 1'b1)
        $display("active-halt reset test done");
        // Watchdog active: option and active-halt decide the outcome
        @(posedge CLK);
        WATCHDOG_ACTIVE <= 1'b1;
        foreach (wd[k])
        begin
            apb(1'b1, OFS_TIMER_CFG, {27'h0, wd[k]});
            instr(1'b0);
            `CHK(WATCHDOG_RESET, k == 0)
            `CHK(MODE, wm[k])
            if (k > 0)
            begin
                pulse(5'h10);
                wait_run();
                `CHK(c, RESTART_CYCLES)
            end
        end
        $display("watchdog test done");
        // Reset in mid-run from full halt comes back in run mode
        apb(1'b1, OFS_TIMER_CFG, 32'h10);
        instr(1'b0);
        `CHK(OSC_ON, 1'b0)
        @(posedge CLK);
        RST_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        @(negedge CLK);
        `CHK(MODE, 3'h0)
        `CHK(OSC_ON, 1'b1)
        `CHK(IRQ_MASK, 1'b1)
        apb(1'b0, OFS_TIMER_CFG, 32'h0);
        `CHK(q[4:0], TIMER_CFG_RESET)
        $display("mid-run reset test done");
        summarize();
    end
endmodule
